/* File: pkg/pmode_pkg.sv */
// constants and types for the power-mode sequencer
package pmode_pkg;
  typedef enum logic [2:0] {
    ST_ACTIVE = 3'b001,
    ST_IDLE   = 3'b010,
    ST_SLEEP  = 3'b100
  } pmode_t;

  localparam int unsigned CLK_HZ           = 20000000;
  localparam int unsigned PA_SETTLE_US     = 250;
  localparam int unsigned PA_SETTLE_CYC    = (PA_SETTLE_US * (CLK_HZ / 1000000));
  localparam int unsigned TIMER_W          = 16;
  localparam logic [15:0] TIMER_RST        = 16'h0000;
  localparam logic [2:0]  MODE_RST         = 3'h1;
  localparam int unsigned WAKE_SRC_W       = 3;
  localparam int unsigned WAKE_TIMER_BIT   = 0;
  localparam int unsigned WAKE_PIN_BIT     = 1;
  localparam int unsigned WAKE_DEBUG_BIT   = 2;
endpackage

/* File: src/power_mode_sequencer.sv */
// power-mode controller: active, idle and deep sleep with wake sources
`timescale 1ns/1ps
module power_mode_sequencer #(
  parameter int unsigned TIMER_WIDTH = pmode_pkg::TIMER_W
) (
  input  wire logic                   clk,
  input  wire logic                   rst_b,
  input  wire logic                   ce,
  input  wire logic                   idle_req,
  input  wire logic                   sleep_req,
  input  wire logic [TIMER_WIDTH-1:0] sleep_period,
  input  wire logic                   irq_any,
  input  wire logic                   wake_request_n,
  input  wire logic                   debug_cmd,
  input  wire logic                   pa_regulator_enable,
  output pmode_pkg::pmode_t           mode,
  output logic                        cpu_run,
  output logic                        core_power_on,
  output logic                        pad_ram_retain,
  output logic                        pa_ready,
  output logic                        pa_enable_fault,
  output logic [pmode_pkg::WAKE_SRC_W-1:0] wake_source
);
  import pmode_pkg::*;

  localparam int unsigned SETTLE_W = $clog2(PA_SETTLE_CYC + 1);
  localparam logic [SETTLE_W-1:0] SETTLE_LAST = SETTLE_W'(PA_SETTLE_CYC - 1);
  localparam pmode_t              MODE_INIT   = pmode_t'(MODE_RST);

  // deep sleep test, shared by the timer, the wake capture and the fault watch
  function automatic logic is_asleep(input pmode_t m);
    is_asleep = (m == ST_SLEEP);
  endfunction

  // execution runs only in the active state
  function automatic logic is_running(input pmode_t m);
    is_running = (m == ST_ACTIVE);
  endfunction

  pmode_t mode_q;
  pmode_t mode_d;
  logic [TIMER_WIDTH-1:0] timer_q;
  logic [SETTLE_W-1:0]    settle_q;
  logic wake_n_s;
  logic debug_s;
  logic pa_en_s;
  logic timer_hit;
  logic wake_pin;
  logic [WAKE_SRC_W-1:0] src_now;
  logic sleep_entry;
  logic wake_any;

  // pins cross in through two flops before use
  sync2 #(.RST_VAL(1'b1)) u_wake (
    .clk   (clk),
    .rst_b (rst_b),
    .ce    (ce),
    .d     (wake_request_n),
    .q     (wake_n_s)
  );
  sync2 #(.RST_VAL(1'b0)) u_dbg (
    .clk   (clk),
    .rst_b (rst_b),
    .ce    (ce),
    .d     (debug_cmd),
    .q     (debug_s)
  );
  sync2 #(.RST_VAL(1'b0)) u_pa (
    .clk   (clk),
    .rst_b (rst_b),
    .ce    (ce),
    .d     (pa_regulator_enable),
    .q     (pa_en_s)
  );

  // wake causes and sleep entry seen this cycle
  assign wake_pin    = !wake_n_s;
  assign timer_hit   = is_asleep(mode_q) && (timer_q == '0);
  assign sleep_entry = !is_asleep(mode_q) && is_asleep(mode_d);
  assign wake_any    = (src_now != '0);

  always_comb begin
    src_now = '0;
    src_now[WAKE_TIMER_BIT] = timer_hit;
    src_now[WAKE_PIN_BIT]   = wake_pin;
    src_now[WAKE_DEBUG_BIT] = debug_s;
  end

  // mode transitions
  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      ST_ACTIVE: begin
        if (sleep_req) begin
          mode_d = ST_SLEEP;
        end else if (idle_req) begin
          mode_d = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (irq_any || wake_pin) begin
          mode_d = ST_ACTIVE;
        end
      end
      ST_SLEEP: begin
        if (wake_any) begin
          mode_d = ST_ACTIVE;
        end
      end
      default: mode_d = ST_ACTIVE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_q <= MODE_INIT;
    end else if (ce) begin
      mode_q <= mode_d;
    end
  end

  // sleep timer: loaded on entry, counts down while asleep
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      timer_q <= TIMER_WIDTH'(TIMER_RST);
    end else if (ce) begin
      if (sleep_entry) begin
        timer_q <= sleep_period;
      end else if (is_asleep(mode_q) && timer_q != '0) begin
        timer_q <= timer_q - TIMER_WIDTH'(1);
      end
    end
  end

  // outputs, one register per concern
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode <= MODE_INIT;
    end else if (ce) begin
      mode <= mode_d;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cpu_run <= 1'b1;
    end else if (ce) begin
      cpu_run <= is_running(mode_d);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      core_power_on <= 1'b1;
    end else if (ce) begin
      core_power_on <= !is_asleep(mode_d);
    end
  end

  // pad domain stays powered in every mode
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pad_ram_retain <= 1'b1;
    end else if (ce) begin
      pad_ram_retain <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wake_source <= '0;
    end else if (ce) begin
      if (is_asleep(mode_q) && wake_any) begin
        wake_source <= src_now;
      end
    end
  end

  // amplifier enable watch: settle count restarts whenever the enable drops
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      settle_q <= '0;
    end else if (ce) begin
      if (!pa_en_s) begin
        settle_q <= '0;
      end else if (settle_q != SETTLE_LAST) begin
        settle_q <= settle_q + SETTLE_W'(1);
      end
    end
  end

  // ready only once the count has run its full length with the enable high
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pa_ready <= 1'b0;
    end else if (ce) begin
      pa_ready <= pa_en_s && (settle_q == SETTLE_LAST);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pa_enable_fault <= 1'b0;
    end else if (ce) begin
      // high while asleep is legal when tied flagged only as information
      pa_enable_fault <= is_asleep(mode_q) && pa_en_s;
    end
  end
endmodule

/* File: src/sync2.sv */
// two-flop synchroniser for single-bit pin inputs
`timescale 1ns/1ps
module sync2 #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic ce,
  input  wire logic d,
  output logic      q
);
  logic meta_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= RST_VAL;
      q      <= RST_VAL;
    end else if (ce) begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

/* File: verification/pa_host_model.sv */
// host model: amplifier enable, wake pin and settle count
`timescale 1ns/1ps
module pa_host_model #(
  parameter int unsigned SETTLE = 5000
) (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic go_sleep,
  input  wire logic go_wake,
  output logic      pa_regulator_enable,
  output logic      wake_request_n,
  output logic      tx_ok
);
  logic [12:0] cnt_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pa_regulator_enable <= 1'b1;
      wake_request_n <= 1'b1;
    end else begin
      if (go_sleep) pa_regulator_enable <= 1'b0;
      else if (go_wake) pa_regulator_enable <= 1'b1;
      wake_request_n <= ~go_wake;
    end
  end
  // settle count kept apart from processor wake
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) cnt_q <= 13'h0000;
    else if (!pa_regulator_enable) cnt_q <= 13'h0000;
    else if (cnt_q != 13'(SETTLE)) cnt_q <= cnt_q + 13'h0001;
  end
  assign tx_ok = (cnt_q == 13'(SETTLE));
endmodule

/* File: verification/pmode_asserts.sv */
// checks on the power-mode sequencer ports
`timescale 1ns/1ps
module pmode_asserts import pmode_pkg::*; #(
  parameter int unsigned TIMER_WIDTH = 16
) (
  input wire logic                   clk,
  input wire logic                   rst_b,
  input wire logic                   idle_req,
  input wire logic                   sleep_req,
  input wire logic [TIMER_WIDTH-1:0] sleep_period,
  input wire logic                   irq_any,
  input wire logic                   wake_request_n,
  input wire logic                   pa_regulator_enable,
  input wire pmode_t                 mode,
  input wire logic                   cpu_run,
  input wire logic                   core_power_on,
  input wire logic                   pad_ram_retain,
  input wire logic                   pa_ready,
  input wire logic [2:0]             wake_source
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence timer_go;
    mode == ST_ACTIVE && sleep_req && sleep_period == 5 && wake_request_n;
  endsequence
  sequence slept6;
    (mode == ST_SLEEP) [*6];
  endsequence
  pad_retain_a: assert property (pad_ram_retain)
    else $error("pad retain low");
  sleep_entry_a: assert property (mode == ST_ACTIVE && sleep_req |=> !core_power_on)
    else $error("sleep entry missed");
  idle_entry_a: assert property (mode == ST_ACTIVE && idle_req && !sleep_req |=> mode == ST_IDLE)
    else $error("idle entry missed");
  idle_wake_a: assert property (mode == ST_IDLE && irq_any |=> mode == ST_ACTIVE)
    else $error("idle not left");
  cpu_run_a: assert property (cpu_run == (mode == ST_ACTIVE))
    else $error("cpu run wrong");
  core_off_a: assert property (core_power_on == (mode != ST_SLEEP))
    else $error("core power wrong");
  pin_wake_a: assert property ((!wake_request_n && !sleep_req) [*4] |-> mode != ST_SLEEP)
    else $error("pin wake late");
  timer_wake_a: assert property (timer_go |=> slept6 ##1 wake_source == 3'h1)
    else $error("timer wake wrong");
  pa_drop_a: assert property ((!pa_regulator_enable) [*4] |-> !pa_ready)
    else $error("ready without enable");
endmodule

/* File: verification/testbench.sv */
// testbench for the power-mode sequencer
`timescale 1ns/1ps
module testbench;
  import pmode_pkg::*;
  logic clk, rst_b, idle_req, sleep_req, irq_any, debug_cmd, go_sleep, go_wake;
  logic pa_en, wake_n, tx_ok, cpu_run, core_on, retain, pa_ready, fault;
  logic [15:0] sleep_period;
  logic [2:0]  wake_src;
  pmode_t      mode;
  int n_errors = 0;
  int samples_checked = 0;
  pa_host_model #(.SETTLE(PA_SETTLE_CYC)) host_u (.clk(clk), .rst_b(rst_b), .go_sleep(go_sleep),
    .go_wake(go_wake), .pa_regulator_enable(pa_en), .wake_request_n(wake_n), .tx_ok(tx_ok));
  power_mode_sequencer dut_u (.clk(clk), .rst_b(rst_b), .ce(1'b1), .idle_req(idle_req),
    .sleep_req(sleep_req), .sleep_period(sleep_period), .irq_any(irq_any),
    .wake_request_n(wake_n), .debug_cmd(debug_cmd), .pa_regulator_enable(pa_en), .mode(mode),
    .cpu_run(cpu_run), .core_power_on(core_on), .pad_ram_retain(retain),
    .pa_ready(pa_ready), .pa_enable_fault(fault), .wake_source(wake_src));
  task automatic chk(string what, logic [2:0] exp, logic [2:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic enter(logic [15:0] p, logic drop);
    @(posedge clk);
    {sleep_req, go_sleep} <= {1'b1, drop};
    sleep_period <= p;
    @(posedge clk);
    {sleep_req, go_sleep} <= 2'h0;
    #1 chk("sleep", ST_SLEEP, mode);
  endtask
  task automatic t_idle;
    @(posedge clk);
    idle_req <= 1'b1;
    @(posedge clk);
    {idle_req, sleep_req} <= 2'h1;
    #1 chk("idle", ST_IDLE, mode);
    chk("cpu run", 3'h0, {2'h0, cpu_run});
    @(posedge clk);
    {sleep_req, irq_any} <= 2'h1;
    #1 chk("refused", ST_IDLE, mode);
    @(posedge clk);
    irq_any <= 1'b0;
    #1 chk("irq", ST_ACTIVE, mode);
  endtask
  task automatic t_timer;
    enter(16'h0005, 1'b1);
    cyc(5);
    #1 chk("asleep", ST_SLEEP, mode);
    chk("fault", 3'h0, {2'h0, fault});
    cyc(1);
    #1 chk("timer src", 3'h1, wake_src);
  endtask
  task automatic t_wake(logic pin, logic [2:0] src);
    enter(16'hFFFF, 1'b1);
    @(posedge clk);
    {go_wake, debug_cmd} <= {pin, ~pin};
    cyc(6);
    {go_wake, debug_cmd} <= 2'h0;
    #1 chk("wake", ST_ACTIVE, mode);
    chk("wake src", src, wake_src);
  endtask
  task automatic t_pa;
    cyc(4900);
    #1 chk("early", 3'h0, {2'h0, pa_ready});
    cyc(200);
    #1 chk("settled", {2'h0, tx_ok}, {2'h0, pa_ready});
  endtask
  task automatic t_tied;
    enter(16'hFFFF, 1'b0);
    cyc(2);
    #1 chk("tied fault", 3'h1, {2'h0, fault});
    chk("tied ready", 3'h1, {2'h0, pa_ready});
  endtask
  task automatic close_out;
    if (n_errors == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    cyc(20000);
    n_errors++;
    close_out();
  end
  initial begin
    {rst_b, idle_req, sleep_req, irq_any, debug_cmd, go_sleep, go_wake} = 7'h00;
    sleep_period = 16'h0000;
    cyc(2);
    rst_b <= 1'b1;
    #1 chk("reset", 3'h6, {retain, core_on, pa_ready});
    t_idle();
    t_timer();
    t_wake(1'b0, 3'h4);
    t_wake(1'b1, 3'h2);
    t_pa();
    t_tied();
    close_out();
  end
endmodule
bind power_mode_sequencer pmode_asserts #(.TIMER_WIDTH(TIMER_WIDTH)) chk_u (.clk(clk),
  .rst_b(rst_b), .idle_req(idle_req), .sleep_req(sleep_req), .sleep_period(sleep_period),
  .irq_any(irq_any), .wake_request_n(wake_request_n), .pa_regulator_enable(pa_regulator_enable),
  .mode(mode), .cpu_run(cpu_run), .core_power_on(core_power_on), .pad_ram_retain(pad_ram_retain),
  .pa_ready(pa_ready), .wake_source(wake_source));
